// File: ddrcd_assertions.sv
// bus-side checks between the controller and dram ends
`timescale 1ns/1ns
`include "ddrcd_params.svh"
module ddrcd_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DDRCD_BA_W-1:0] ba,
  input wire logic [`DDRCD_ADDR_W-1:0] addr,
  input wire logic dm,
  input wire logic [`DDRCD_DQ_W-1:0] dq_wr,
  input wire logic [`DDRCD_DQ_W-1:0] dq_rd,
  input wire logic dq_rd_valid
);
  default clocking dflt_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  wire nop_des = cs_n || (ras_n && cas_n && we_n);
  wire rd_c = !cs_n && ras_n && !cas_n && we_n;
  wire wr_c = !cs_n && ras_n && !cas_n && !we_n;
  wire ref_c = !cs_n && !ras_n && !cas_n && we_n;
  logic [3:0] run;
  // ==========================================
  // helper: length of the current read beat run
  // a new read restarts the run, yet the previous burst's beat one edge later still counts, so back-to-back eight-beat reads count nine
  always_ff @(posedge core_clk) begin
    if (!resetn || (rd_c && cke)) begin
      run <= 4'h0;
    end else if (dq_rd_valid) begin
      run <= run + 4'h1;
    end else begin
      run <= 4'h0;
    end
  end
  // ==========================================
  // assertions
  chk_pd_entry: assert property ($fell(cke) |-> nop_des || ref_c)
    else $error("clock enable fell with a non-idle command");
  chk_pd_exit: assert property ($rose(cke) |-> nop_des)
    else $error("clock enable rose without nop or deselect");
  chk_low_quiet: assert property (!cke && !$past(cke) |-> nop_des)
    else $error("command issued while clock enable low");
  chk_cke_stable: assert property (!nop_des && cke |-> $past(cke))
    else $error("command issued on the clock enable rising edge");
  chk_rd_answer: assert property (rd_c && cke |-> ##[1:4] dq_rd_valid)
    else $error("read produced no read beats");
  chk_wr_quiet: assert property (wr_c && cke |=> !dq_rd_valid)
    else $error("write followed by read beats");
  chk_burst_min: assert property ($rose(dq_rd_valid) |-> dq_rd_valid[*4])
    else $error("read burst shorter than four beats");
  chk_burst_max: assert property (run <= 4'h8)
    else $error("read burst longer than eight beats");
  cover property (rd_c && cke && addr[10]);
  cover property ($fell(cke) && nop_des);
  cover property ($fell(cke) && ref_c);
  cover property (!cs_n && ras_n && cas_n && !we_n && addr[10]);
endmodule : ddrcd_assertions

// File: ddrcd_ctrl.sv
// controller end: turns user requests into command bus cycles
`timescale 1ns/1ns
`include "ddrcd_params.svh"
module ddrcd_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire ddrcd_pkg::ddrcd_cmd_t req_cmd,
  input wire logic [`DDRCD_BA_W-1:0] req_ba,
  input wire logic [`DDRCD_ADDR_W-1:0] req_addr,
  input wire logic req_dm,
  input wire logic [`DDRCD_DQ_W-1:0] req_wdata,
  output logic req_ready,
  output logic req_err,
  output logic [`DDRCD_DQ_W-1:0] rd_data,
  output logic rd_valid,
  ddrcd_if.ctrl bus
);
  // =========================================
  // state
  logic [`DDRCD_NUM_BANKS-1:0] open;
  logic [`DDRCD_NUM_BANKS-1:0] next_open;
  logic cke_r, cs_r, ras_r, cas_r, we_r, dm_r, err_r;
  logic next_cke, next_cs, next_ras, next_cas, next_we, next_err;
  logic [`DDRCD_BA_W-1:0] ba_r;
  logic [`DDRCD_ADDR_W-1:0] addr_r;
  logic [`DDRCD_DQ_W-1:0] wd_r, rd_r;
  logic rdv_r;
  logic rdy_r;
  logic init_done;
  logic next_init_done;
  logic [3:0] code;
  logic legal;
  logic all_idle;

  assign all_idle = (open == '0);
  // =========================================
  // command encoding
  always_comb begin
    next_open = open;
    next_cke = cke_r;
    next_err = 1'b0;
    next_init_done = init_done;
    code = 4'hf;
    legal = 1'b1;
    if (req_valid) begin
      unique case (req_cmd)
        ddrcd_pkg::DDRCD_CMD_ACT: begin
          code = 4'h3;
          legal = !open[req_ba];
          next_open[req_ba] = legal;
        end
        ddrcd_pkg::DDRCD_CMD_PRE: begin
          code = 4'h2;
          next_open[req_ba] = 1'b0;
        end
        ddrcd_pkg::DDRCD_CMD_PREA: begin
          code = 4'h2;
          next_open = '0;
        end
        ddrcd_pkg::DDRCD_CMD_WR: begin
          code = 4'h4;
          legal = open[req_ba];
          if (legal && req_addr[`DDRCD_AP_BIT]) next_open[req_ba] = 1'b0;
        end
        ddrcd_pkg::DDRCD_CMD_RD: begin
          code = 4'h5;
          legal = open[req_ba];
          if (legal && req_addr[`DDRCD_AP_BIT]) next_open[req_ba] = 1'b0;
        end
        ddrcd_pkg::DDRCD_CMD_MRS: begin
          code = 4'h0;
          legal = all_idle;
        end
        ddrcd_pkg::DDRCD_CMD_REF: begin
          code = 4'h1;
          legal = all_idle;
        end
        ddrcd_pkg::DDRCD_CMD_SREF: begin
          code = 4'h1;
          legal = all_idle && cke_r;
          if (legal) next_cke = 1'b0;
        end
        ddrcd_pkg::DDRCD_CMD_PDN: begin
          code = 4'h7;
          legal = all_idle && cke_r;
          if (legal) next_cke = 1'b0;
        end
        ddrcd_pkg::DDRCD_CMD_ZQL, ddrcd_pkg::DDRCD_CMD_ZQS: begin
          code = 4'h6;
          legal = all_idle;
          if (legal) next_init_done = 1'b1;
        end
        ddrcd_pkg::DDRCD_CMD_NOP: begin
          code = 4'h7;
          next_cke = 1'b1;
        end
        default: begin
          code = 4'hf;
        end
      endcase
      // sleeping device accepts only nop; wake first
      if (!cke_r && req_cmd != ddrcd_pkg::DDRCD_CMD_NOP) legal = 1'b0;
      // until long calibration only mrs, long zq and nop leave the controller
      if (!init_done && !(req_cmd inside {ddrcd_pkg::DDRCD_CMD_MRS,
          ddrcd_pkg::DDRCD_CMD_ZQL, ddrcd_pkg::DDRCD_CMD_NOP})) legal = 1'b0;
      if (!legal) begin
        code = 4'hf;
        next_open = open;
        next_cke = cke_r;
        next_init_done = init_done;
        next_err = 1'b1;
      end
    end
    {next_cs, next_ras, next_cas, next_we} = code;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      open <= '0;
      cke_r <= 1'b1;
      {cs_r, ras_r, cas_r, we_r} <= 4'hf;
      ba_r <= '0;
      addr_r <= '0;
      dm_r <= 1'b0;
      wd_r <= '0;
      err_r <= 1'b0;
      init_done <= 1'b0;
      rd_r <= '0;
      rdv_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      open <= next_open;
      cke_r <= next_cke;
      {cs_r, ras_r, cas_r, we_r} <= {next_cs, next_ras, next_cas, next_we};
      ba_r <= req_ba;
      addr_r <= req_addr;
      dm_r <= req_dm;
      wd_r <= req_wdata;
      err_r <= next_err;
      init_done <= next_init_done;
      rd_r <= bus.dq_rd;
      rdv_r <= bus.dq_rd_valid;
      rdy_r <= 1'b1;
    end
  end

  assign bus.cke = cke_r;
  assign bus.cs_n = cs_r;
  assign bus.ras_n = ras_r;
  assign bus.cas_n = cas_r;
  assign bus.we_n = we_r;
  assign bus.ba = ba_r;
  assign bus.addr = addr_r;
  assign bus.dm = dm_r;
  assign bus.dq_wr = wd_r;
  // ready from a flop, low only while reset holds
  assign req_ready = rdy_r;
  assign req_err = err_r;
  assign rd_data = rd_r;
  assign rd_valid = rdv_r;
endmodule : ddrcd_ctrl

// File: ddrcd_dram.sv
// dram end: command decode, bank state, burst sequencing
`timescale 1ns/1ns
`include "ddrcd_params.svh"
// Operation
// - activate opens given row in given bank
// - controller activates bank before read or write
// - write decode with stable clock enable
// - read decode with stable clock enable
// - a10 high auto-precharges after burst
// - a12 picks burst length when on-the-fly
// - mode set needs all banks idle
// - clock enable fall with nop enters power-down
// - clock enable rise with nop exits power-down
// - masked write beats are not stored
// - classify using previous and current clock enable
// - idle or active checked per addressed bank
// - one eight-bit word moves per beat
// - bursts of eight or chopped four
// - only nop between last mode set and calibration
module ddrcd_dram #(
  parameter int NUM_BANKS = `DDRCD_NUM_BANKS,
  parameter int DQ_W = `DDRCD_DQ_W,
  parameter int COL_W = `DDRCD_COL_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  ddrcd_if.dram bus,
  output ddrcd_pkg::ddrcd_cmd_t cmd,
  output logic [`DDRCD_BA_W-1:0] cmd_ba,
  output logic [`DDRCD_ADDR_W-1:0] cmd_addr,
  output logic [NUM_BANKS-1:0] bank_active,
  output logic [`DDRCD_ADDR_W-1:0] act_row,
  output logic powered_down,
  output logic self_refresh,
  output logic [1:0] mr0_bl,
  output logic beat_valid,
  output logic beat_write,
  output logic beat_store,
  output logic [COL_W-1:0] beat_col,
  output logic [DQ_W-1:0] beat_data
);
  // =========================================
  // decode state
  typedef enum {DDRCD_RUN, DDRCD_PDN, DDRCD_SREF} ddrcd_pwr_t;
  ddrcd_pwr_t pwr, next_pwr;
  logic cke_prev;
  logic [NUM_BANKS-1:0] next_active;
  logic [`DDRCD_ADDR_W-1:0] next_row;
  ddrcd_pkg::ddrcd_cmd_t next_cmd;
  logic [1:0] next_bl;
  logic [3:0] enc;
  logic stable, nopish, bank_on, all_idle;
  // burst state
  logic [3:0] beats_left, next_beats_left;
  logic bwr, next_bwr, bap, next_bap;
  logic [`DDRCD_BA_W-1:0] bba, next_bba;
  logic [COL_W-1:0] bcol, next_bcol;
  logic next_bv, next_bst;
  logic [DQ_W-1:0] next_bdata;
  logic rd_beat;

  assign enc = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  assign stable = cke_prev && bus.cke;
  assign nopish = bus.cs_n || (enc == 4'h7);
  assign bank_on = bank_active[bus.ba];
  assign all_idle = (bank_active == '0);

  // =========================================
  // command classification
  always_comb begin
    next_cmd = ddrcd_pkg::DDRCD_CMD_NONE;
    next_active = bank_active;
    next_row = act_row;
    next_pwr = pwr;
    next_bl = mr0_bl;
    unique case (pwr)
      DDRCD_RUN: begin
        if (cke_prev && !bus.cke) begin
          if (enc == 4'h1 && all_idle) begin
            next_cmd = ddrcd_pkg::DDRCD_CMD_SREF;
            next_pwr = DDRCD_SREF;
          end else if (nopish) begin
            next_cmd = ddrcd_pkg::DDRCD_CMD_PDN;
            next_pwr = DDRCD_PDN;
          end
        end else if (stable && !bus.cs_n) begin
          unique case (enc)
            4'h3: if (!bank_on) begin
              next_cmd = ddrcd_pkg::DDRCD_CMD_ACT;
              next_active[bus.ba] = 1'b1;
              next_row = bus.addr;
            end
            4'h2: if (bus.addr[`DDRCD_AP_BIT]) begin
              next_cmd = ddrcd_pkg::DDRCD_CMD_PREA;
              next_active = '0;
            end else begin
              next_cmd = ddrcd_pkg::DDRCD_CMD_PRE;
              next_active[bus.ba] = 1'b0;
            end
            4'h4: if (bank_on) next_cmd = ddrcd_pkg::DDRCD_CMD_WR;
            4'h5: if (bank_on) next_cmd = ddrcd_pkg::DDRCD_CMD_RD;
            4'h0: if (all_idle) begin
              next_cmd = ddrcd_pkg::DDRCD_CMD_MRS;
              if (bus.ba == '0) next_bl = bus.addr[1:0];
            end
            4'h1: if (all_idle) next_cmd = ddrcd_pkg::DDRCD_CMD_REF;
            4'h6: if (all_idle) begin
              if (bus.addr[`DDRCD_AP_BIT]) next_cmd = ddrcd_pkg::DDRCD_CMD_ZQL;
              else next_cmd = ddrcd_pkg::DDRCD_CMD_ZQS;
            end
            4'h7: next_cmd = ddrcd_pkg::DDRCD_CMD_NOP;
            default: next_cmd = ddrcd_pkg::DDRCD_CMD_NONE;
          endcase
        end
      end
      DDRCD_PDN, DDRCD_SREF: begin
        if (!cke_prev && bus.cke && nopish) next_pwr = DDRCD_RUN;
      end
    endcase
    // auto-precharge closes the bank as the burst ends
    if (beats_left == 4'h1 && bap) next_active[bba] = 1'b0;
  end

  // =========================================
  // burst sequencing, one beat per pin transfer
  always_comb begin
    next_beats_left = beats_left;
    next_bwr = bwr;
    next_bap = bap;
    next_bba = bba;
    next_bcol = bcol;
    next_bv = 1'b0;
    next_bst = 1'b0;
    next_bdata = bus.dq_wr;
    if (beats_left != 4'h0) begin
      next_bv = 1'b1;
      next_bst = bwr && !bus.dm;
      next_beats_left = beats_left - 4'h1;
      next_bcol = bcol + 1'b1;
    end
    if (next_cmd == ddrcd_pkg::DDRCD_CMD_WR || next_cmd == ddrcd_pkg::DDRCD_CMD_RD) begin
      next_bwr = (next_cmd == ddrcd_pkg::DDRCD_CMD_WR);
      next_bap = bus.addr[`DDRCD_AP_BIT];
      next_bba = bus.ba;
      next_bcol = bus.addr[COL_W-1:0];
      if (mr0_bl == `DDRCD_MR_BL_BC4 ||
          (mr0_bl == `DDRCD_MR_BL_OTF && !bus.addr[`DDRCD_BC_BIT]))
        next_beats_left = 4'(`DDRCD_BC4_BEATS);
      else
        next_beats_left = 4'(`DDRCD_BL8_BEATS);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pwr <= DDRCD_RUN;
      cke_prev <= 1'b0;
      cmd <= ddrcd_pkg::DDRCD_CMD_NONE;
      cmd_ba <= '0;
      cmd_addr <= '0;
      bank_active <= '0;
      act_row <= '0;
      mr0_bl <= `DDRCD_MR_BL_BL8;
      beats_left <= 4'h0;
      bwr <= 1'b0;
      bap <= 1'b0;
      bba <= '0;
      bcol <= '0;
      beat_valid <= 1'b0;
      beat_write <= 1'b0;
      beat_store <= 1'b0;
      beat_col <= '0;
      beat_data <= '0;
      powered_down <= 1'b0;
      self_refresh <= 1'b0;
      rd_beat <= 1'b0;
    end else begin
      pwr <= next_pwr;
      cke_prev <= bus.cke;
      cmd <= next_cmd;
      cmd_ba <= bus.ba;
      cmd_addr <= bus.addr;
      bank_active <= next_active;
      act_row <= next_row;
      mr0_bl <= next_bl;
      beats_left <= next_beats_left;
      bwr <= next_bwr;
      bap <= next_bap;
      bba <= next_bba;
      bcol <= next_bcol;
      beat_valid <= next_bv;
      beat_write <= bwr;
      beat_store <= next_bst;
      beat_col <= bcol;
      beat_data <= next_bdata;
      powered_down <= (next_pwr == DDRCD_PDN);
      self_refresh <= (next_pwr == DDRCD_SREF);
      rd_beat <= next_bv && !bwr;
    end
  end

  // no array behind this end; reads echo the beat column
  assign bus.dq_rd = beat_col[DQ_W-1:0];
  // read strobe kept in its own flop, in step with beat_valid
  assign bus.dq_rd_valid = rd_beat;
endmodule : ddrcd_dram

// File: ddrcd_if.sv
// command bus between controller and dram decoder
`timescale 1ns/1ns
`include "ddrcd_params.svh"
interface ddrcd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`DDRCD_BA_W-1:0] ba;
  logic [`DDRCD_ADDR_W-1:0] addr;
  logic dm;
  logic [`DDRCD_DQ_W-1:0] dq_wr;
  logic [`DDRCD_DQ_W-1:0] dq_rd;
  logic dq_rd_valid;
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_wr,
    input dq_rd, dq_rd_valid
  );
  modport dram (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_wr,
    output dq_rd, dq_rd_valid
  );
endinterface : ddrcd_if

// File: ddrcd_params.svh
// timing and field constants for the dram command decode block
`ifndef DDRCD_PARAMS_SVH
`define DDRCD_PARAMS_SVH
`define DDRCD_NUM_BANKS 8
`define DDRCD_BA_W 3
`define DDRCD_ADDR_W 16
`define DDRCD_DQ_W 8
`define DDRCD_AP_BIT 10
`define DDRCD_BC_BIT 12
`define DDRCD_BL8_BEATS 8
`define DDRCD_BC4_BEATS 4
`define DDRCD_COL_W 10
`define DDRCD_MR_BL_OTF 2'h1
`define DDRCD_MR_BL_BC4 2'h2
`define DDRCD_MR_BL_BL8 2'h0
`endif

// File: ddrcd_pkg.sv
// types shared by both ends of the dram command decode block
package ddrcd_pkg;
  typedef enum logic [3:0] {
    DDRCD_CMD_NONE,
    DDRCD_CMD_ACT,
    DDRCD_CMD_PRE,
    DDRCD_CMD_PREA,
    DDRCD_CMD_WR,
    DDRCD_CMD_RD,
    DDRCD_CMD_MRS,
    DDRCD_CMD_REF,
    DDRCD_CMD_SREF,
    DDRCD_CMD_PDN,
    DDRCD_CMD_ZQL,
    DDRCD_CMD_ZQS,
    DDRCD_CMD_NOP
  } ddrcd_cmd_t;
endpackage : ddrcd_pkg

// File: tb_dram_command_decode.sv
// self-checking bench joining controller and dram ends
`timescale 1ns/1ns
module tb_dram_command_decode;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  ddrcd_pkg::ddrcd_cmd_t req_cmd = ddrcd_pkg::DDRCD_CMD_NOP;
  logic [2:0] req_ba = 3'h0;
  logic [15:0] req_addr = 16'h0;
  logic req_dm = 1'b0;
  logic [7:0] req_wdata = 8'h0;
  logic req_err, powered_down, self_refresh, beat_valid, beat_write, beat_store;
  ddrcd_pkg::ddrcd_cmd_t cmd;
  logic [7:0] bank_active;
  logic [15:0] act_row, a, row;
  logic [1:0] mr0_bl, mode;
  logic [2:0] cmd_ba;
  logic [15:0] cmd_addr;
  logic [9:0] beat_col;
  logic [7:0] beat_data, rd_data;
  logic rd_valid, req_ready;
  logic [2:0] b;
  logic wr, pa;
  integer seed;
  int comparisons = 0;
  int n_mismatch = 0;
  int err_cnt = 0;
  int exp_err = 0;
  int i, n, m;
  ddrcd_if bus_if();
  ddrcd_ctrl ddrcd_ctrl_i (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .req_dm(req_dm),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_err(req_err), .rd_data(rd_data),
    .rd_valid(rd_valid),
    .bus(bus_if));
  ddrcd_dram ddrcd_dram_i (.core_clk(core_clk), .resetn(resetn), .bus(bus_if), .cmd(cmd),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .bank_active(bank_active), .act_row(act_row),
    .powered_down(powered_down), .self_refresh(self_refresh), .mr0_bl(mr0_bl),
    .beat_valid(beat_valid), .beat_write(beat_write), .beat_store(beat_store),
    .beat_col(beat_col), .beat_data(beat_data));
  ddrcd_assertions ddrcd_assertions_i (.core_clk(core_clk), .resetn(resetn), .cke(bus_if.cke),
    .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
    .ba(bus_if.ba), .addr(bus_if.addr), .dm(bus_if.dm), .dq_wr(bus_if.dq_wr),
    .dq_rd(bus_if.dq_rd), .dq_rd_valid(bus_if.dq_rd_valid));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (req_err === 1'b1) begin
      err_cnt++;
    end
  end
  // ==========================================
  // shared tasks
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // request taken one edge later, decoded the edge after; checked just past that
  task automatic send(ddrcd_pkg::ddrcd_cmd_t c, logic [2:0] sb, logic [15:0] sa);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_ba <= sb;
    req_addr <= sa;
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : send
  function automatic int exp_beats(logic [1:0] m, logic a12);
    return (m == 2'h2 || (m == 2'h1 && !a12)) ? 4 : 8;
  endfunction : exp_beats
  // ==========================================
  // main sequence
  initial begin
    seed = 32'h8230;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    send(ddrcd_pkg::DDRCD_CMD_NOP, 3'h0, 16'h0);
    chk("ready", req_ready, 1'b1);
    send(ddrcd_pkg::DDRCD_CMD_ACT, 3'h0, 16'h0);
    exp_err++;
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_NONE);
    send(ddrcd_pkg::DDRCD_CMD_ZQL, 3'h0, 16'h0400);
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_ZQL);
    send(ddrcd_pkg::DDRCD_CMD_ZQS, 3'h0, 16'h0);
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_ZQS);
    send(ddrcd_pkg::DDRCD_CMD_REF, 3'h0, 16'h0);
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_REF);
    // mode set to another register leaves the burst field alone
    send(ddrcd_pkg::DDRCD_CMD_MRS, 3'h2, 16'h0002);
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_MRS);
    chk("mr0_bl", mr0_bl, 2'h0);
    send(ddrcd_pkg::DDRCD_CMD_PDN, 3'h0, 16'h0);
    chk("pdn", powered_down, 1'b1);
    send(ddrcd_pkg::DDRCD_CMD_NOP, 3'h0, 16'h0);
    repeat (2) @(posedge core_clk);
    chk("pdn", powered_down, 1'b0);
    send(ddrcd_pkg::DDRCD_CMD_SREF, 3'h0, 16'h0);
    chk("sref", self_refresh, 1'b1);
    send(ddrcd_pkg::DDRCD_CMD_NOP, 3'h0, 16'h0);
    repeat (2) @(posedge core_clk);
    chk("sref", self_refresh, 1'b0);
    send(ddrcd_pkg::DDRCD_CMD_RD, 3'h1, 16'h0);
    exp_err++;
    chk("cmd", cmd, ddrcd_pkg::DDRCD_CMD_NONE);
    @(posedge core_clk);
    chk("err", 16'(err_cnt), 16'(exp_err));
    for (i = 0; i < 12; i++) begin
      mode = 2'(i % 3);
      send(ddrcd_pkg::DDRCD_CMD_MRS, 3'h0, {14'h0, mode});
      chk("mr0_bl", mr0_bl, mode);
      b = 3'($random(seed));
      row = 16'($random(seed));
      send(ddrcd_pkg::DDRCD_CMD_ACT, b, row);
      chk("active", bank_active[b], 1'b1);
      chk("row", act_row, row);
      chk("cmd_ba", cmd_ba, b);
      chk("cmd_addr", cmd_addr, row);
      wr = 1'($random(seed));
      a = 16'($random(seed)) & 16'h14f8;
      req_dm <= 1'($random(seed));
      req_wdata <= 8'($random(seed));
      send(wr ? ddrcd_pkg::DDRCD_CMD_WR : ddrcd_pkg::DDRCD_CMD_RD, b, a);
      chk("cmd", cmd, wr ? ddrcd_pkg::DDRCD_CMD_WR : ddrcd_pkg::DDRCD_CMD_RD);
      n = 0;
      m = 0;
      repeat (10) begin
        if (rd_valid === 1'b1) begin
          chk("rd_data", rd_data, a[7:0] + 8'(m));
          m++;
        end
        if (beat_valid === 1'b1) begin
          chk("col", beat_col, a[9:0] + 10'(n));
          chk("dir", beat_write, wr);
          chk("store", beat_store, wr && !req_dm);
          if (wr) chk("wdata", beat_data, req_wdata);
          n++;
        end
        @(posedge core_clk);
        #1;
      end
      chk("beats", 16'(n), 16'(exp_beats(mode, a[12])));
      chk("rd_beats", 16'(m), wr ? 16'h0 : 16'(n));
      chk("autopre", bank_active[b], !a[10]);
      if (!a[10]) begin
        pa = i[2];
        send(pa ? ddrcd_pkg::DDRCD_CMD_PREA : ddrcd_pkg::DDRCD_CMD_PRE, b, {5'h0, pa, 10'h0});
        chk("cmd", cmd, pa ? ddrcd_pkg::DDRCD_CMD_PREA : ddrcd_pkg::DDRCD_CMD_PRE);
        chk("closed", bank_active[b], 1'b0);
      end
    end
    chk("err", 16'(err_cnt), 16'(exp_err));
    print_verdict();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_dram_command_decode
